// ==== inc/ips_pkg.sv ====
// Constants and field layout of the interrupt priority select register.
// What this block does
// RQ1 - Bit 6 sets serial peripheral interface interrupt priority, clear low, set high.
// RQ2 - Bit 5 sets timer 2 interrupt priority, clear low, set high.
// RQ3 - Bit 4 sets UART interrupt priority level.
// RQ4 - Every writable priority bit: zero means low level, one means high level.
// RQ5 - Bit 3 sets timer 1 priority; setting it raises timer 1 high.
// RQ6 - Bit 2 sets external interrupt 1 priority level.
// RQ7 - Bit 1 sets timer 0 interrupt priority level.
// RQ8 - Bit 0 sets external interrupt 0 priority; clear bit gives low.
package ips_pkg;

  // ==========================================================================
  // Register location and reset value.
  localparam logic [7:0] IPS_SFR_ADDR  = 8'hb8;
  localparam logic [7:0] IPS_RESET_VAL = 8'h80;

  // ==========================================================================
  // Bit addressing: bit n of the register sits at bit address base plus n.
  localparam logic [7:0] IPS_BIT_BASE  = 8'hb8;
  localparam logic [4:0] IPS_BIT_GROUP = 5'h17;

  // ==========================================================================
  // Field positions.
  localparam int IPS_SPI_POS  = 6;
  localparam int IPS_TMR2_POS = 5;
  localparam int IPS_UART_POS = 4;
  localparam int IPS_TMR1_POS = 3;
  localparam int IPS_EXT1_POS = 2;
  localparam int IPS_TMR0_POS = 1;
  localparam int IPS_EXT0_POS = 0;

  // ==========================================================================
  // Bits that software may change; bit 7 is read only.
  localparam logic [7:0] IPS_WR_MASK   = 8'h7f;

  // ==========================================================================
  // Priority level encoding.
  localparam logic       IPS_LVL_LOW   = 1'b0;
  localparam logic       IPS_LVL_HIGH  = 1'b1;

endpackage : ips_pkg

// ==== inc/ips_reg_if.sv ====
// Carrier between the access decoder and the register store.
`timescale 1ns/10ps
`default_nettype none
interface ips_reg_if;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;
  logic [7:0] value;

  modport ctl (
    output wr_mask,
    output wr_data,
    input  value
  );

  modport store (
    input  wr_mask,
    input  wr_data,
    output value
  );
endinterface : ips_reg_if
`default_nettype wire

// ==== logic/ips_prio_store.sv ====
// Storage flip-flops of the interrupt priority select register.
`timescale 1ns/10ps
`default_nettype none
module ips_prio_store (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Register carrier.
  ips_reg_if.store  reg_if
);

  logic [7:0] prio_reg;
  logic [7:0] prio_next;

  // ==========================================================================
  // Masked update; the read-only top bit keeps its reset value.
  always_comb begin
    prio_next = (prio_reg & ~(reg_if.wr_mask & ips_pkg::IPS_WR_MASK)) |
                (reg_if.wr_data & reg_if.wr_mask & ips_pkg::IPS_WR_MASK); // [RQ4]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prio_reg <= ips_pkg::IPS_RESET_VAL;
    end else begin
      prio_reg <= prio_next;
    end
  end

  assign reg_if.value = prio_reg;

endmodule : ips_prio_store
`default_nettype wire

// ==== logic/ips_interrupt_priority_select.sv ====
// Special-function register access and priority level outputs of seven interrupt sources.
`timescale 1ns/10ps
`default_nettype none
module ips_interrupt_priority_select (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Byte access from the core, decoded at IPS_SFR_ADDR only.
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_rvalid_o,
  // Single-bit access from the core.
  input  wire logic [7:0] bit_addr_i,
  input  wire logic       bit_wr_i,
  input  wire logic       bit_wdata_i,
  input  wire logic       bit_rd_i,
  output logic            bit_rdata_o,
  output logic            bit_rvalid_o,
  // Priority levels, zero low and one high.
  output logic            serial_periph_prio_bit_o,
  output logic            timer_two_prio_bit_o,
  output logic            uart_prio_bit_o,
  output logic            timer_one_prio_bit_o,
  output logic            ext_irq_one_prio_bit_o,
  output logic            timer_zero_prio_bit_o,
  output logic            ext_irq_zero_prio_bit_o
);

  // ==========================================================================
  // Address decoding.
  function automatic logic ips_byte_hit(input logic [7:0] addr);
    ips_byte_hit = (addr == ips_pkg::IPS_SFR_ADDR);
  endfunction : ips_byte_hit

  function automatic logic ips_bit_hit(input logic [7:0] addr);
    ips_bit_hit = (addr[7:3] == ips_pkg::IPS_BIT_GROUP);
  endfunction : ips_bit_hit

  function automatic logic [7:0] ips_bit_onehot(input logic [2:0] idx);
    ips_bit_onehot = 8'h01 << idx;
  endfunction : ips_bit_onehot

  ips_reg_if reg_if ();

  logic       byte_wr_hit;
  logic       byte_rd_hit;
  logic       bit_wr_hit;
  logic       bit_rd_hit;
  logic [7:0] bit_sel;

  assign byte_wr_hit = sfr_wr_i & ips_byte_hit(sfr_addr_i);
  assign byte_rd_hit = sfr_rd_i & ips_byte_hit(sfr_addr_i);
  assign bit_wr_hit  = bit_wr_i & ips_bit_hit(bit_addr_i);
  assign bit_rd_hit  = bit_rd_i & ips_bit_hit(bit_addr_i);
  assign bit_sel     = ips_bit_onehot(bit_addr_i[2:0]);

  // ==========================================================================
  // Write merge; a byte write takes precedence over a bit write in one cycle.
  always_comb begin
    reg_if.wr_mask = 8'h00;
    reg_if.wr_data = 8'h00;
    if (byte_wr_hit) begin
      reg_if.wr_mask = 8'hff;
      reg_if.wr_data = sfr_wdata_i;
    end else if (bit_wr_hit) begin
      reg_if.wr_mask = bit_sel;
      reg_if.wr_data = {8{bit_wdata_i}} & bit_sel;
    end
  end

  ips_prio_store u_store (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .reg_if  (reg_if.store)
  );

  // ==========================================================================
  // Read path; returns the value held before any write in the same cycle.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       brdata_reg;
  logic       brdata_next;
  logic       bvalid_reg;
  logic       bvalid_next;

  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = byte_rd_hit;
    brdata_next = brdata_reg;
    bvalid_next = bit_rd_hit;
    if (byte_rd_hit) begin
      rdata_next = reg_if.value;
    end
    if (bit_rd_hit) begin
      brdata_next = |(reg_if.value & bit_sel);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      brdata_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      brdata_reg <= brdata_next;
      bvalid_reg <= bvalid_next;
    end
  end

  assign sfr_rdata_o  = rdata_reg;
  assign sfr_rvalid_o = rvalid_reg;
  assign bit_rdata_o  = brdata_reg;
  assign bit_rvalid_o = bvalid_reg;

  // ==========================================================================
  // Priority levels, taken straight from the storage flip-flops.
  assign serial_periph_prio_bit_o = reg_if.value[ips_pkg::IPS_SPI_POS];  // [RQ1] [RQ4]
  assign timer_two_prio_bit_o     = reg_if.value[ips_pkg::IPS_TMR2_POS]; // [RQ2] [RQ4]
  assign uart_prio_bit_o          = reg_if.value[ips_pkg::IPS_UART_POS]; // [RQ3] [RQ4]
  assign timer_one_prio_bit_o     = reg_if.value[ips_pkg::IPS_TMR1_POS]; // [RQ5] [RQ4]
  assign ext_irq_one_prio_bit_o   = reg_if.value[ips_pkg::IPS_EXT1_POS]; // [RQ6] [RQ4]
  assign timer_zero_prio_bit_o    = reg_if.value[ips_pkg::IPS_TMR0_POS]; // [RQ7] [RQ4]
  assign ext_irq_zero_prio_bit_o  = reg_if.value[ips_pkg::IPS_EXT0_POS]; // [RQ8] [RQ4]

endmodule : ips_interrupt_priority_select
`default_nettype wire

// ==== dv/ips_prio_chk.sv ====
// Port assertions of the interrupt priority select register.
`timescale 1ns/10ps
`default_nettype none
module ips_prio_chk (
  // Clock, reset and byte access.
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_rvalid_o,
  // Bit access.
  input wire logic [7:0] bit_addr_i,
  input wire logic       bit_rd_i,
  input wire logic       bit_rdata_o,
  input wire logic       bit_rvalid_o,
  // Priority levels.
  input wire logic       serial_periph_prio_bit_o,
  input wire logic       timer_two_prio_bit_o,
  input wire logic       uart_prio_bit_o,
  input wire logic       timer_one_prio_bit_o,
  input wire logic       ext_irq_one_prio_bit_o,
  input wire logic       timer_zero_prio_bit_o,
  input wire logic       ext_irq_zero_prio_bit_o
);
  wire logic [6:0] lv = {serial_periph_prio_bit_o, timer_two_prio_bit_o, uart_prio_bit_o,
    timer_one_prio_bit_o, ext_irq_one_prio_bit_o, timer_zero_prio_bit_o, ext_irq_zero_prio_bit_o};
  wire logic [7:0] rv = {1'b1, lv};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr; sfr_wr_i && sfr_addr_i == 8'hb8; endsequence
  sequence s_rd; sfr_rd_i && sfr_addr_i == 8'hb8; endsequence
  property p_b6; s_wr |=> serial_periph_prio_bit_o == $past(sfr_wdata_i[6]); endproperty
  a_b6: assert property (p_b6) else $error("bit 6 level wrong");
  property p_b5; s_wr |=> timer_two_prio_bit_o == $past(sfr_wdata_i[5]); endproperty
  a_b5: assert property (p_b5) else $error("bit 5 level wrong");
  property p_b4; s_wr |=> uart_prio_bit_o == $past(sfr_wdata_i[4]); endproperty
  a_b4: assert property (p_b4) else $error("bit 4 level wrong");
  property p_b3; s_wr |=> timer_one_prio_bit_o == $past(sfr_wdata_i[3]); endproperty
  a_b3: assert property (p_b3) else $error("bit 3 level wrong");
  property p_b2; s_wr |=> ext_irq_one_prio_bit_o == $past(sfr_wdata_i[2]); endproperty
  a_b2: assert property (p_b2) else $error("bit 2 level wrong");
  property p_b1; s_wr |=> timer_zero_prio_bit_o == $past(sfr_wdata_i[1]); endproperty
  a_b1: assert property (p_b1) else $error("bit 1 level wrong");
  property p_b0; s_wr |=> ext_irq_zero_prio_bit_o == $past(sfr_wdata_i[0]); endproperty
  a_b0: assert property (p_b0) else $error("bit 0 level wrong");
  property p_rd; s_rd |=> sfr_rvalid_o && sfr_rdata_o == {1'b1, $past(lv)}; endproperty
  a_rd: assert property (p_rd) else $error("read value wrong");
  sequence s_brd; bit_rd_i && bit_addr_i[7:3] == 5'h17; endsequence
  property p_brd; s_brd |=> bit_rvalid_o && bit_rdata_o == $past(rv[bit_addr_i[2:0]]); endproperty
  a_brd: assert property (p_brd) else $error("bit read value wrong");
  property p_norv; !(sfr_rd_i && sfr_addr_i == 8'hb8) |=> !sfr_rvalid_o; endproperty
  a_norv: assert property (p_norv) else $error("read valid without read");
endmodule : ips_prio_chk
bind ips_interrupt_priority_select ips_prio_chk u_ips_prio_chk (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench of the interrupt priority select register.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, bit_wr_i = 0, bit_wdata_i = 0, bit_rd_i = 0;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, bit_addr_i = 0, sfr_rdata_o, m = 8'h80, er = 0;
  logic sfr_rvalid_o, bit_rdata_o, bit_rvalid_o, eb = 0;
  logic [6:0] lv;
  int err_total = 0, checked = 0;
  always #2.5 clk_i = ~clk_i;
  ips_interrupt_priority_select u_ips_interrupt_priority_select (.*, .serial_periph_prio_bit_o(lv[6]),
    .timer_two_prio_bit_o(lv[5]), .uart_prio_bit_o(lv[4]), .timer_one_prio_bit_o(lv[3]),
    .ext_irq_one_prio_bit_o(lv[2]), .timer_zero_prio_bit_o(lv[1]), .ext_irq_zero_prio_bit_o(lv[0]));
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic op(logic [7:0] sa, logic sw, logic [7:0] sd, logic sr, logic [7:0] ba, logic bw, logic bd, logic br);
    logic [7:0] old;
    logic       sv;
    logic       bv;
    old = m;
    {sfr_addr_i, sfr_wr_i, sfr_wdata_i, sfr_rd_i} = {sa, sw, sd, sr};
    {bit_addr_i, bit_wr_i, bit_wdata_i, bit_rd_i} = {ba, bw, bd, br};
    if (bw && ba[7:3] == 5'h17 && ba != 8'hbf) m[ba[2:0]] = bd;
    if (sw && sa == 8'hb8) m = {1'b1, sd[6:0]};
    sv = sr && sa == 8'hb8;
    bv = br && ba[7:3] == 5'h17;
    if (sv) er = old;
    if (bv) eb = old[ba[2:0]];
    @(negedge clk_i);
    chk("levels", {1'b0, m[6:0]}, {1'b0, lv});
    chk("byte read", er, sfr_rdata_o);
    chk("byte valid", {7'h0, sv}, {7'h0, sfr_rvalid_o});
    chk("bit read", {6'h0, bv, eb}, {6'h0, bit_rvalid_o, bit_rdata_o});
  endtask : op
  initial begin
    void'($urandom(32'hc60282ba));
    repeat (5) @(negedge clk_i);
    rst_n_i = 1;
    op(8'hb8, 0, 0, 1, 8'hbf, 0, 0, 1);
    for (int i = 0; i < 8; i++) op(8'hb8, 0, 0, 1, 8'(8'hb8 + i), 1, 1, 1);
    for (int i = 0; i < 8; i++) op(8'hb8, 1, 8'hff, 1, 8'(8'hb8 + i), 1, 0, 1);
    repeat (80) op(8'(8'hb7 + $urandom_range(2)), 1'($urandom_range(1)), 8'($urandom), 1'($urandom_range(1)),
      8'(8'hb6 + $urandom_range(10)), 1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)));
    give_verdict;
  end
  initial begin
    #5000;
    err_total++;
    give_verdict;
  end
endmodule : tb
`default_nettype wire
